// ### core/watchdog_regs.svh
// Summary of operation
// - Watchdog reset cause flag, bit 3, set by watchdog reset; power-on or written zero clears.
// - Brown-out reset cause flag, bit 2, set by brown-out; power-on or written zero clears.
// - Pin reset cause flag, bit 1, set by pin reset; power-on or written zero clears.
// - Power-on flag, bit 0, set at power-on; only a written zero clears it.
// - Registers answer at data offsets; cause status also at I/O offset 0x34 (0x20 lower, inside 0x00-0x3F), control not.
// - Timeout irq flag, bit 7, set on timeout in irq modes; vector or written one clears.
// - Timeout interrupt requested only with global and watchdog interrupt enables both set.
// - Unprogrammed fuse: reset/irq enables select stopped, irq, reset, or irq-then-reset mode.
// - Irq-then-reset: first timeout sets flag; vector clears flag and enable, leaving reset mode.
// - Irq-then-reset: a second timeout before service gives a system reset.
// - Programmed always-on fuse forces reset mode whatever the enable bits hold.
// - Change unlock bit, bit 4, clears by itself four cycles after being written one.
// - Clearing reset enable or changing prescale only accepted while change unlock is set.
// - Reset enable is forced to one while the watchdog reset cause flag is set.
// - Prescale codes 0 to 9 select 2048 doubling to 1048576 oscillator cycles.
// - Prescale bit 3 sits at bit 5; prescale bits 2:0 sit at bits 2:0.
// - The counter advances on ticks of the separate watchdog oscillator.
// - The restart instruction clears the watchdog counter.
// - A watchdog system reset is a pulse of one system clock cycle.
`ifndef WATCHDOG_REGS_SVH
`define WATCHDOG_REGS_SVH

`define CAUSE_STATUS_OFF 16'h0054
`define WDT_CONTROL_OFF 16'h0060
`define IO_SPACE_BASE 16'h0020
`define IO_SPACE_LAST 16'h003F

`define CAUSE_STATUS_RST 8'h00
`define WDT_CONTROL_RST 8'h00

`define CAUSE_WDT_BIT 3
`define CAUSE_BROWNOUT_BIT 2
`define CAUSE_PIN_BIT 1
`define CAUSE_POWER_ON_BIT 0

`define CTL_IRQ_FLAG_BIT 7
`define CTL_IRQ_EN_BIT 6
`define CTL_PRESCALE_HI_BIT 5
`define CTL_UNLOCK_BIT 4
`define CTL_RESET_EN_BIT 3
`define CTL_PRESCALE_LO_MSB 2

`define UNLOCK_CYCLES 3'h4
`define TIMEOUT_BASE_CYCLES 21'h000800
`define PRESCALE_MAX_CODE 4'h9

`endif

// ### core/watchdog_pkg.sv
package watchdog_pkg;

  typedef enum logic [1:0] {
    MODE_STOPPED,
    MODE_IRQ,
    MODE_RESET,
    MODE_IRQ_RESET
  } wdt_mode_t;

  typedef struct packed {
    logic watchdog_reset_flag;
    logic brownout_reset_flag;
    logic pin_reset_flag;
    logic power_on_reset_flag;
    logic timeout_irq_flag;
    logic timeout_irq_enable;
    logic timeout_reset_enable;
    logic change_unlock;
    logic [2:0] unlock_left;
    logic [3:0] timeout_prescale_select;
    logic [19:0] count;
    logic reset_pulse;
    logic [7:0] rdata;
  } wdt_state_t;

endpackage

// ### core/watchdog_reset_status.sv
`timescale 1ns/1ps
`include "watchdog_regs.svh"

module watchdog_reset_status #(
  parameter int ADDR_W = 16
) (
  // Clock and power-on reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Core register access
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic io_space_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  // Core status and instruction events
  input wire logic global_irq_enable_i,
  input wire logic irq_vector_taken_i,
  input wire logic restart_i,
  // Watchdog oscillator tick, fuse and reset sources
  input wire logic osc_tick_i,
  input wire logic always_on_fuse_i,
  input wire logic brownout_reset_i,
  input wire logic pin_reset_i,
  // Interrupt request and system reset
  output logic irq_o,
  output logic sys_reset_o
);

  watchdog_pkg::wdt_state_t st_r;
  watchdog_pkg::wdt_state_t st_nxt;

  // Data space and I/O space decode of one register
  function automatic logic reg_hit(
    input logic [ADDR_W-1:0] addr,
    input logic io_space,
    input logic [15:0] offset
  );
    logic [15:0] io_off;
    logic [15:0] a16;
    io_off = offset - `IO_SPACE_BASE;
    a16 = 16'(addr);
    if (io_space) begin
      reg_hit = (offset >= `IO_SPACE_BASE) && (io_off <= `IO_SPACE_LAST) && (a16 == io_off);
    end else begin
      reg_hit = (a16 == offset);
    end
  endfunction

  // Last count value before a timeout for a prescale code
  function automatic logic [19:0] timeout_last(input logic [3:0] sel);
    logic [3:0] s;
    logic [20:0] span;
    s = (sel > `PRESCALE_MAX_CODE) ? `PRESCALE_MAX_CODE : sel;
    span = `TIMEOUT_BASE_CYCLES << s;
    timeout_last = span[19:0] - 20'h00001;
  endfunction

  logic fuse_programmed;
  logic wde_eff;
  logic timeout_irq_enable_eff;
  watchdog_pkg::wdt_mode_t mode;
  logic cause_hit;
  logic ctl_hit;
  logic timeout;
  logic do_reset;
  logic set_irq_flag;
  logic sys_event;
  logic [7:0] cause_rd;
  logic [7:0] ctl_rd;

  assign fuse_programmed = ~always_on_fuse_i;
  assign wde_eff = st_r.timeout_reset_enable | st_r.watchdog_reset_flag | fuse_programmed;
  assign timeout_irq_enable_eff = st_r.timeout_irq_enable & ~fuse_programmed;
  assign cause_hit = reg_hit(addr_i, io_space_i, `CAUSE_STATUS_OFF);
  assign ctl_hit = reg_hit(addr_i, io_space_i, `WDT_CONTROL_OFF);

  always_comb begin
    unique case ({wde_eff, timeout_irq_enable_eff})
      2'b00: mode = watchdog_pkg::MODE_STOPPED;
      2'b01: mode = watchdog_pkg::MODE_IRQ;
      2'b10: mode = watchdog_pkg::MODE_RESET;
      2'b11: mode = watchdog_pkg::MODE_IRQ_RESET;
    endcase
  end

  assign timeout = (mode != watchdog_pkg::MODE_STOPPED) && osc_tick_i && !restart_i
    && (st_r.count == timeout_last(st_r.timeout_prescale_select));

  always_comb begin
    do_reset = 1'b0;
    set_irq_flag = 1'b0;
    if (timeout) begin
      unique case (mode)
        watchdog_pkg::MODE_IRQ: begin
          set_irq_flag = 1'b1;
        end
        watchdog_pkg::MODE_RESET: begin
          do_reset = 1'b1;
        end
        watchdog_pkg::MODE_IRQ_RESET: begin
          if (st_r.timeout_irq_flag) begin
            do_reset = 1'b1;
          end else begin
            set_irq_flag = 1'b1;
          end
        end
        watchdog_pkg::MODE_STOPPED: begin
          do_reset = 1'b0;
        end
      endcase
    end
  end

  // Any non power-on system reset clears the control register, but reset enable stays one while the watchdog reset cause flag is set
  assign sys_event = st_r.reset_pulse | brownout_reset_i | pin_reset_i;

  assign cause_rd = {4'h0, st_r.watchdog_reset_flag, st_r.brownout_reset_flag,
    st_r.pin_reset_flag, st_r.power_on_reset_flag};
  assign ctl_rd = {st_r.timeout_irq_flag, timeout_irq_enable_eff, st_r.timeout_prescale_select[3],
    st_r.change_unlock, wde_eff, st_r.timeout_prescale_select[2:0]};

  always_comb begin
    st_nxt = st_r;
    st_nxt.reset_pulse = do_reset;

    // Counter
    if (restart_i || timeout || sys_event) begin
      st_nxt.count = 20'h00000;
    end else if (osc_tick_i && mode != watchdog_pkg::MODE_STOPPED) begin
      st_nxt.count = st_r.count + 20'h00001;
    end

    // Unlock window countdown
    if (st_r.change_unlock) begin
      if (st_r.unlock_left <= 3'h1) begin
        st_nxt.change_unlock = 1'b0;
        st_nxt.unlock_left = 3'h0;
      end else begin
        st_nxt.unlock_left = st_r.unlock_left - 3'h1;
      end
    end

    // Control register writes
    if (wr_en_i && ctl_hit) begin
      if (wdata_i[`CTL_IRQ_FLAG_BIT]) begin
        st_nxt.timeout_irq_flag = 1'b0;
      end
      st_nxt.timeout_irq_enable = wdata_i[`CTL_IRQ_EN_BIT];
      if (st_r.change_unlock) begin
        st_nxt.timeout_reset_enable = wdata_i[`CTL_RESET_EN_BIT];
        st_nxt.timeout_prescale_select = {wdata_i[`CTL_PRESCALE_HI_BIT],
          wdata_i[`CTL_PRESCALE_LO_MSB:0]};
        st_nxt.change_unlock = 1'b0;
        st_nxt.unlock_left = 3'h0;
      end else begin
        if (wdata_i[`CTL_RESET_EN_BIT]) begin
          st_nxt.timeout_reset_enable = 1'b1;
        end
        if (wdata_i[`CTL_UNLOCK_BIT] && wdata_i[`CTL_RESET_EN_BIT]) begin
          st_nxt.change_unlock = 1'b1;
          st_nxt.unlock_left = `UNLOCK_CYCLES;
        end
      end
    end

    // Vector taken clears the flag, and the enable when reset is also armed
    if (irq_vector_taken_i && st_r.timeout_irq_flag) begin
      st_nxt.timeout_irq_flag = 1'b0;
      if (wde_eff) begin
        st_nxt.timeout_irq_enable = 1'b0;
      end
    end

    if (sys_event) begin
      st_nxt.timeout_irq_flag = 1'b0;
      st_nxt.timeout_irq_enable = 1'b0;
      st_nxt.timeout_reset_enable = 1'b0;
      st_nxt.change_unlock = 1'b0;
      st_nxt.unlock_left = 3'h0;
      st_nxt.timeout_prescale_select = 4'h0;
    end

    if (set_irq_flag) begin
      st_nxt.timeout_irq_flag = 1'b1;
    end

    // Cause flags: written zero clears, written one keeps, events win
    if (wr_en_i && cause_hit) begin
      if (!wdata_i[`CAUSE_WDT_BIT]) begin
        st_nxt.watchdog_reset_flag = 1'b0;
      end
      if (!wdata_i[`CAUSE_BROWNOUT_BIT]) begin
        st_nxt.brownout_reset_flag = 1'b0;
      end
      if (!wdata_i[`CAUSE_PIN_BIT]) begin
        st_nxt.pin_reset_flag = 1'b0;
      end
      if (!wdata_i[`CAUSE_POWER_ON_BIT]) begin
        st_nxt.power_on_reset_flag = 1'b0;
      end
    end
    if (do_reset) begin
      st_nxt.watchdog_reset_flag = 1'b1;
    end
    if (brownout_reset_i) begin
      st_nxt.brownout_reset_flag = 1'b1;
    end
    if (pin_reset_i) begin
      st_nxt.pin_reset_flag = 1'b1;
    end

    if (st_nxt.watchdog_reset_flag) begin
      st_nxt.timeout_reset_enable = 1'b1;
    end

    // Registered read data
    if (rd_en_i) begin
      if (cause_hit) begin
        st_nxt.rdata = cause_rd;
      end else if (ctl_hit) begin
        st_nxt.rdata = ctl_rd;
      end else begin
        st_nxt.rdata = 8'h00;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_r <= '0;
      st_r.power_on_reset_flag <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata_o = st_r.rdata;
  assign irq_o = st_r.timeout_irq_flag & timeout_irq_enable_eff & global_irq_enable_i;
  assign sys_reset_o = st_r.reset_pulse;

endmodule

// ### test/watchdog_reset_status_checker.sv
`timescale 1ns/1ps
module watchdog_reset_status_checker (
  // Watched ports
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [15:0] addr_i,
  input wire logic io_space_i,
  input wire logic rd_en_i,
  input wire logic global_irq_enable_i,
  input wire logic irq_vector_taken_i,
  input wire logic restart_i,
  input wire logic always_on_fuse_i,
  input wire logic brownout_reset_i,
  input wire logic pin_reset_i,
  input wire logic [7:0] rdata_o,
  input wire logic irq_o,
  input wire logic sys_reset_o
);
  logic [11:0] gap_r;
  logic [11:0] gap_nxt;
  logic unmap;
  logic stat;
  assign unmap = io_space_i ? addr_i != 16'h0034 : (addr_i != 16'h0054 && addr_i != 16'h0060);
  assign stat = io_space_i ? addr_i == 16'h0034 : addr_i == 16'h0054;
  // Cycles since a restart or a system, pin or brown-out reset
  always_comb begin
    gap_nxt = gap_r + {11'h000, gap_r != 12'hFFF};
    if (restart_i || sys_reset_o || pin_reset_i || brownout_reset_i) begin
      gap_nxt = 12'h000;
    end
  end
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      gap_r <= 12'h000;
    end else begin
      gap_r <= gap_nxt;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  a_reset_pulse_one: assert property (sys_reset_o |=> !sys_reset_o) else $error("reset pulse too long");
  a_irq_gated: assert property (irq_o |-> global_irq_enable_i) else $error("irq without global enable");
  a_fuse_no_irq: assert property (!always_on_fuse_i |-> !irq_o) else $error("irq with fuse programmed");
  a_unmapped_zero: assert property (rd_en_i && unmap |=> rdata_o == 8'h00) else $error("unmapped read");
  a_status_upper: assert property (rd_en_i && stat |=> rdata_o[7:4] == 4'h0) else $error("status high bits");
  a_rdata_hold: assert property (!rd_en_i |=> $stable(rdata_o)) else $error("read data moved");
  a_reset_spacing: assert property (sys_reset_o |-> gap_r >= 12'd2000) else $error("timeout too early");
  a_vector_clears: assert property (irq_vector_taken_i && irq_o |=> !irq_o) else $error("vector kept irq");
  a_reset_drops_irq: assert property (sys_reset_o |=> !irq_o) else $error("irq after reset");
  c_sys_reset: cover property (sys_reset_o);
  c_irq: cover property ($rose(irq_o));
  c_io_read: cover property (rd_en_i && io_space_i);
endmodule

// ### test/tb_watchdog_reset_status.sv
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin miscompares++; $display("ERROR %0t got %h want %h", $time, a, b); end end
module tb_watchdog_reset_status;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [15:0] addr_i = 16'h0000;
  logic [7:0] wdata_i = 8'h00;
  logic [7:0] rdata_o;
  logic io_space_i = 1'b0, wr_en_i = 1'b0, rd_en_i = 1'b0, global_irq_enable_i = 1'b0;
  logic irq_vector_taken_i = 1'b0, restart_i = 1'b0, osc_tick_i = 1'b1, always_on_fuse_i = 1'b1;
  logic brownout_reset_i = 1'b0, pin_reset_i = 1'b0, irq_o, sys_reset_o;
  int miscompares = 0, num_checks = 0, cyc = 0, n0, n1, n2;
  always #2 clk_i = ~clk_i;
  watchdog_reset_status i_watchdog_reset_status (.clk_i, .rst_b_i, .addr_i, .io_space_i, .wr_en_i, .rd_en_i,
    .wdata_i, .rdata_o, .global_irq_enable_i, .irq_vector_taken_i, .restart_i, .osc_tick_i, .always_on_fuse_i,
    .brownout_reset_i, .pin_reset_i, .irq_o, .sys_reset_o);
  task automatic wr(logic [15:0] a, logic io, logic [7:0] d);
    @(negedge clk_i) {addr_i, io_space_i, wdata_i, wr_en_i} = {a, io, d, 1'b1};
    @(negedge clk_i) wr_en_i = 1'b0;
  endtask
  task automatic rd(logic [15:0] a, logic io, logic [7:0] e);
    @(negedge clk_i) {addr_i, io_space_i, rd_en_i} = {a, io, 1'b1};
    @(negedge clk_i) rd_en_i = 1'b0;
    `CHK(rdata_o, e)
  endtask
  task automatic pulse(ref logic s);
    @(negedge clk_i) s = 1'b1;
    @(negedge clk_i) s = 1'b0;
  endtask
  task automatic wait_rst(output int n);
    n = 0;
    while (sys_reset_o !== 1'b1 && n < 5000) begin
      @(negedge clk_i) n++;
    end
    `CHK(sys_reset_o, 1'b1)
    @(negedge clk_i);
  endtask
  task automatic t_causes();
    rd(16'h0054, 0, 8'h01);
    rd(16'h0034, 1, 8'h01);
    rd(16'h0040, 1, 8'h00);
    pulse(pin_reset_i);
    rd(16'h0054, 0, 8'h03);
    pulse(brownout_reset_i);
    rd(16'h0054, 0, 8'h07);
    wr(16'h0054, 0, 8'hFF);
    rd(16'h0054, 0, 8'h07);
    wr(16'h0034, 1, 8'h00);
    rd(16'h0054, 0, 8'h00);
  endtask
  task automatic t_irq();
    wr(16'h0060, 0, 8'h40);
    pulse(restart_i);
    repeat (2060) @(negedge clk_i);
    rd(16'h0060, 0, 8'hC0);
    `CHK(irq_o, 1'b0)
    global_irq_enable_i = 1'b1;
    @(negedge clk_i) `CHK(irq_o, 1'b1)
    wr(16'h0060, 0, 8'hC0);
    rd(16'h0060, 0, 8'h40);
    wr(16'h0060, 0, 8'h00);
  endtask
  task automatic t_irq_reset();
    wr(16'h0060, 0, 8'h48);
    pulse(restart_i);
    repeat (2060) @(negedge clk_i);
    rd(16'h0060, 0, 8'hC8);
    pulse(irq_vector_taken_i);
    rd(16'h0060, 0, 8'h08);
    wait_rst(n0);
    rd(16'h0054, 0, 8'h08);
    rd(16'h0060, 0, 8'h08);
    wr(16'h0060, 0, 8'h48);
    pulse(restart_i);
    wait_rst(n0);
    `CHK(n0 > 4000, 1'b1)
  endtask
  task automatic t_protect();
    wr(16'h0054, 0, 8'h00);
    wr(16'h0060, 0, 8'h00);
    rd(16'h0060, 0, 8'h08);
    wr(16'h0060, 0, 8'h09);
    rd(16'h0060, 0, 8'h08);
    wr(16'h0060, 0, 8'h18);
    rd(16'h0060, 0, 8'h18);
    repeat (2) @(negedge clk_i);
    rd(16'h0060, 0, 8'h08);
    wr(16'h0060, 0, 8'h18);
    wr(16'h0060, 0, 8'h00);
    rd(16'h0060, 0, 8'h00);
    wr(16'h0060, 0, 8'h18);
    wr(16'h0060, 0, 8'h2F);
    rd(16'h0060, 0, 8'h2F);
    wr(16'h0060, 0, 8'h18);
    wr(16'h0060, 0, 8'h00);
    rd(16'h0060, 0, 8'h00);
  endtask
  task automatic t_prescale();
    wr(16'h0060, 0, 8'h08);
    pulse(restart_i);
    wait_rst(n0);
    wait_rst(n1);
    `CHK(n1 > 2040 && n1 < 2060, 1'b1)
    wr(16'h0060, 0, 8'h18);
    wr(16'h0060, 0, 8'h09);
    pulse(restart_i);
    wait_rst(n2);
    `CHK(n2 - n0, 2048)
  endtask
  task automatic t_fuse();
    always_on_fuse_i = 1'b0;
    wr(16'h0060, 0, 8'h40);
    rd(16'h0060, 0, 8'h08);
    pulse(restart_i);
    osc_tick_i = 1'b0;
    repeat (100) @(negedge clk_i);
    osc_tick_i = 1'b1;
    wait_rst(n1);
    `CHK(n1, n0)
    always_on_fuse_i = 1'b1;
  endtask
  task automatic complete_run();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      miscompares++;
      complete_run();
    end
  end
  initial begin
    repeat (16) @(negedge clk_i);
    rst_b_i = 1'b1;
    t_causes();
    t_irq();
    t_irq_reset();
    t_protect();
    t_prescale();
    t_fuse();
    complete_run();
  end
endmodule
bind watchdog_reset_status watchdog_reset_status_checker i_watchdog_reset_status_checker (.clk_i, .rst_b_i,
  .addr_i, .io_space_i, .rd_en_i, .global_irq_enable_i, .irq_vector_taken_i, .restart_i, .always_on_fuse_i,
  .brownout_reset_i, .pin_reset_i, .rdata_o, .irq_o, .sys_reset_o);
